// file: logic/sctc_device.sv
// Sensor-side control: registers, standby sequencing, pre-divider
// selection and temperature result. Assumes synchronous inputs on clk.
module sctc_device
    import sctc_pkg::*;
#(
    parameter int LINE_CYCLES  = LINE_CYC,
    parameter int ACT_LINES    = ACTIVE_LINES,
    parameter int BLK_LINES    = BLANK_LINES,
    parameter int WAKE_CYCLES  = WAKE_CYC,
    parameter int TEMP_CYCLES  = TEMP_MEAS_CYC
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    sctc_if.device           bus,
    input  wire logic signed [7:0] temp_celsius,
    input  wire logic [15:0] pix_rate,
    input  wire logic [15:0] out_rate,
    input  wire logic        derate_on,
    output logic             streaming,
    output logic             frame_valid,
    output logic             line_valid,
    output logic             crossing_ok,
    output logic             temp_busy,
    output logic [7:0]       pix_prediv,
    output logic [7:0]       out_prediv
);

    localparam int FRAME_LINES = ACT_LINES + BLK_LINES;
    localparam int CW = $clog2(LINE_CYCLES + 1);
    localparam int RW = $clog2(FRAME_LINES + 1);
    localparam int WW = $clog2(WAKE_CYCLES + 1);
    localparam int TW = $clog2(TEMP_CYCLES + 1);

    sctc_state_type    state_q, state_d;
    logic [7:0]        run_q;
    logic [7:0]        fast_q;
    logic [15:0]       freq_q;
    logic [7:0]        pix_div_q, out_div_q;
    logic              temp_en_q;
    logic [6:0]        temp_val_q;
    logic [TW-1:0]     temp_cnt_q;
    logic              temp_run_q;
    logic              stop_q;
    logic [CW-1:0]     col_q;
    logic [RW-1:0]     row_q;
    logic [WW-1:0]     wake_q;
    logic              ack_q;
    logic [7:0]        rdata_q;

    // Clear pin low is a synchronous internal reset, taken at the next clk edge.
    wire int_rst = !rst_n || !bus.hardware_clear_pin;

    // Write decode.
    wire wr      = bus.cci_req && bus.cci_we;
    wire wr_run  = wr && (bus.cci_addr == SCTC_ADDR_RUN_STATE);
    wire wr_fast = wr && (bus.cci_addr == SCTC_ADDR_FAST_STBY);
    wire wr_fh   = wr && (bus.cci_addr == SCTC_ADDR_CLK_FREQ_H);
    wire wr_fl   = wr && (bus.cci_addr == SCTC_ADDR_CLK_FREQ_L);
    wire wr_temp = wr && (bus.cci_addr == SCTC_ADDR_TEMP);
    wire wr_pdiv = wr && (bus.cci_addr == SCTC_ADDR_PIX_PREDIV);
    wire wr_odiv = wr && (bus.cci_addr == SCTC_ADDR_OUT_PREDIV);
    wire start_req = wr_run && bus.cci_wdata[0];
    wire stop_req  = wr_run && !bus.cci_wdata[0];

    // New frequency value as it stands after this write.
    wire [15:0] freq_new = wr_fh ? {bus.cci_wdata, freq_q[7:0]}
                         : wr_fl ? {freq_q[15:8], bus.cci_wdata}
                         : freq_q;
    wire freq_wr = wr_fh || wr_fl;

    // Band lookup; boundary values fall into the upper band.
    wire in_low  = (freq_new >= SCTC_FREQ_MIN) && (freq_new < SCTC_FREQ_MID);
    wire in_mid  = (freq_new >= SCTC_FREQ_MID) && (freq_new < SCTC_FREQ_TOP);
    wire in_high = (freq_new >= SCTC_FREQ_TOP) && (freq_new <= SCTC_FREQ_MAX);
    wire [7:0] auto_div = in_low ? SCTC_PREDIV_LOW
                        : in_mid ? SCTC_PREDIV_MID
                        : SCTC_PREDIV_HIGH;
    wire auto_load = freq_wr && (in_low || in_mid || in_high);

    // Frame position.
    wire line_end  = (col_q == CW'(LINE_CYCLES - 1));
    wire in_active = (row_q < RW'(ACT_LINES));
    wire last_act  = (row_q == RW'(ACT_LINES - 1));
    wire frame_end = (row_q == RW'(FRAME_LINES - 1)) && line_end;
    wire fast_on   = (fast_q == SCTC_FAST_ENABLE);

    // Point where a pending stop may take effect.
    wire stop_now = stop_q && (!in_active
                  || (line_end && fast_on)
                  || (line_end && last_act));
    wire wake_done = (wake_q == WW'(WAKE_CYCLES - 1));

    // Temperature to code: linear with rounding, top code saturated.
    function automatic logic [6:0] temp_code(input logic signed [7:0] t);
        int c;
        c = int'(t);
        if (c < SCTC_TEMP_LOW_C)
            c = SCTC_TEMP_LOW_C;
        if (c > SCTC_TEMP_HIGH_C)
            c = SCTC_TEMP_HIGH_C;
        c = ((c - SCTC_TEMP_LOW_C) * SCTC_TEMP_SPAN
            + (SCTC_TEMP_HIGH_C - SCTC_TEMP_LOW_C) / 2)
            / (SCTC_TEMP_HIGH_C - SCTC_TEMP_LOW_C);
        if (c > int'(SCTC_TEMP_CODE_MAX))
            c = int'(SCTC_TEMP_CODE_MAX);
        return c[6:0];
    endfunction

    // Measurement starts on stream entry or on enabling while streaming.
    wire temp_start = temp_en_q && state_q == SCTC_ST_WAKE && wake_done
                    || wr_temp && bus.cci_wdata[SCTC_TEMP_EN_BIT]
                       && state_q == SCTC_ST_STREAM;
    wire temp_done  = temp_run_q && (temp_cnt_q == TW'(TEMP_CYCLES - 1));

    // Run state sequencing.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            SCTC_ST_STANDBY:
                if (start_req)
                    state_d = SCTC_ST_WAKE;
            SCTC_ST_WAKE:
                if (stop_req || stop_q)
                    state_d = SCTC_ST_STANDBY;
                else if (wake_done)
                    state_d = SCTC_ST_STREAM;
            SCTC_ST_STREAM:
                if (stop_now)
                    state_d = SCTC_ST_STANDBY;
            default:
                state_d = SCTC_ST_STANDBY;
        endcase
    end

    // State and stop request.
    always_ff @(posedge clk)
    begin
        if (int_rst)
        begin
            state_q <= SCTC_ST_STANDBY;
            stop_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            stop_q  <= (stop_q || stop_req) && (state_d != SCTC_ST_STANDBY);
        end
    end

    // Wake-up counter and frame timing.
    always_ff @(posedge clk)
    begin
        if (int_rst || state_q == SCTC_ST_STANDBY)
        begin
            wake_q <= '0;
            col_q  <= '0;
            row_q  <= '0;
        end
        else if (state_q == SCTC_ST_WAKE)
            wake_q <= wake_q + WW'(1);
        else
        begin
            col_q <= line_end ? '0 : col_q + CW'(1);
            if (line_end)
                row_q <= frame_end ? '0 : row_q + RW'(1);
        end
    end

    // Software-written registers.
    always_ff @(posedge clk)
    begin
        if (int_rst)
        begin
            run_q     <= SCTC_RST_RUN;
            fast_q    <= SCTC_RST_FAST;
            freq_q    <= SCTC_RST_FREQ;
            pix_div_q <= SCTC_RST_PREDIV;
            out_div_q <= SCTC_RST_PREDIV;
            temp_en_q <= 1'b0;
        end
        else
        begin
            if (wr_run)
                run_q <= bus.cci_wdata;
            if (wr_fast)
                fast_q <= bus.cci_wdata;
            freq_q <= freq_new;
            if (auto_load)
            begin
                pix_div_q <= auto_div;
                out_div_q <= auto_div;
            end
            else
            begin
                if (wr_pdiv)
                    pix_div_q <= bus.cci_wdata;
                if (wr_odiv)
                    out_div_q <= bus.cci_wdata;
            end
            if (wr_temp)
                temp_en_q <= bus.cci_wdata[SCTC_TEMP_EN_BIT];
        end
    end

    // Temperature measurement; result is written by hardware only.
    always_ff @(posedge clk)
    begin
        if (int_rst)
        begin
            temp_run_q <= 1'b0;
            temp_cnt_q <= '0;
            temp_val_q <= SCTC_RST_TEMP;
        end
        else if (temp_start)
        begin
            temp_run_q <= 1'b1;
            temp_cnt_q <= '0;
        end
        else if (temp_done)
        begin
            temp_run_q <= 1'b0;
            temp_val_q <= temp_code(temp_celsius);
        end
        else if (temp_run_q)
            temp_cnt_q <= temp_cnt_q + TW'(1);
    end

    // Read data mux; unmapped addresses read zero.
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (bus.cci_addr)
            SCTC_ADDR_RUN_STATE:  rd_mux = run_q;
            SCTC_ADDR_FAST_STBY:  rd_mux = fast_q;
            SCTC_ADDR_CLK_FREQ_H: rd_mux = freq_q[15:8];
            SCTC_ADDR_CLK_FREQ_L: rd_mux = freq_q[7:0];
            SCTC_ADDR_TEMP:       rd_mux = {temp_en_q, temp_val_q};
            SCTC_ADDR_PIX_PREDIV: rd_mux = pix_div_q;
            SCTC_ADDR_OUT_PREDIV: rd_mux = out_div_q;
            default:              rd_mux = 8'h00;
        endcase
    end

    // Each request is answered one cycle later.
    always_ff @(posedge clk)
    begin
        if (int_rst)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            ack_q <= bus.cci_req;
            if (bus.cci_req && !bus.cci_we)
                rdata_q <= rd_mux;
        end
    end

    // Outputs.
    assign bus.cci_ack     = ack_q;
    assign bus.cci_rdata   = rdata_q;
    assign bus.dev_standby = (state_q == SCTC_ST_STANDBY);
    assign streaming       = (state_q == SCTC_ST_STREAM);
    assign frame_valid     = streaming && in_active;
    assign line_valid      = frame_valid;
    assign crossing_ok     = (pix_rate <= out_rate)
                           || derate_on;
    assign temp_busy       = temp_run_q;
    assign pix_prediv      = pix_div_q;
    assign out_prediv      = out_div_q;

endmodule // sctc_device

// file: logic/sctc_pkg.sv
// Constants, register map and types for the standby, clock and temperature
// control block. Assumes one 50 MHz clock shared by both ends.
package sctc_pkg;

    // Register offsets on the control bus.
    localparam logic [15:0] SCTC_ADDR_RUN_STATE  = 16'h0100;
    localparam logic [15:0] SCTC_ADDR_FAST_STBY  = 16'h0106;
    localparam logic [15:0] SCTC_ADDR_CLK_FREQ_H = 16'h012A;
    localparam logic [15:0] SCTC_ADDR_CLK_FREQ_L = 16'h012B;
    localparam logic [15:0] SCTC_ADDR_TEMP       = 16'h0140;
    localparam logic [15:0] SCTC_ADDR_PIX_PREDIV = 16'h0304;
    localparam logic [15:0] SCTC_ADDR_OUT_PREDIV = 16'h0305;

    // Field values and positions.
    localparam logic [7:0] SCTC_RUN_STANDBY  = 8'h00;
    localparam logic [7:0] SCTC_RUN_STREAM   = 8'h01;
    localparam logic [7:0] SCTC_FAST_ENABLE  = 8'h01;
    localparam int         SCTC_TEMP_EN_BIT  = 7;
    localparam logic [7:0] SCTC_PREDIV_LOW   = 8'h01;
    localparam logic [7:0] SCTC_PREDIV_MID   = 8'h02;
    localparam logic [7:0] SCTC_PREDIV_HIGH  = 8'h03;

    // Input clock bands in MHz.
    localparam logic [15:0] SCTC_FREQ_MIN = 16'h0006;
    localparam logic [15:0] SCTC_FREQ_MID = 16'h000C;
    localparam logic [15:0] SCTC_FREQ_TOP = 16'h0018;
    localparam logic [15:0] SCTC_FREQ_MAX = 16'h001B;

    // Reset values.
    localparam logic [7:0]  SCTC_RST_RUN    = 8'h00;
    localparam logic [7:0]  SCTC_RST_FAST   = 8'h00;
    localparam logic [15:0] SCTC_RST_FREQ   = 16'h000C;
    localparam logic [7:0]  SCTC_RST_PREDIV = 8'h02;
    localparam logic [6:0]  SCTC_RST_TEMP   = 7'h00;

    // Temperature code mapping.
    localparam int SCTC_TEMP_LOW_C  = -10;
    localparam int SCTC_TEMP_HIGH_C = 95;
    localparam int SCTC_TEMP_SPAN   = 128;
    localparam logic [6:0] SCTC_TEMP_CODE_MAX = 7'h7F;

    // Timing.
    localparam int CLK_MHZ          = 50;
    localparam int CLR_MAX_US       = 10;
    localparam int CLR_MAX_CYC      = CLR_MAX_US * CLK_MHZ;
    localparam int WAKE_US          = 1200;
    localparam int WAKE_CYC         = WAKE_US * CLK_MHZ;
    localparam int TEMP_MEAS_CYC    = 32;
    localparam int LINE_CYC         = 64;
    localparam int ACTIVE_LINES     = 16;
    localparam int BLANK_LINES      = 4;

    typedef enum logic [1:0] {
        SCTC_ST_STANDBY = 2'b00,
        SCTC_ST_WAKE    = 2'b01,
        SCTC_ST_STREAM  = 2'b10
    } sctc_state_type;

    typedef enum logic [1:0] {
        SCTC_H_IDLE = 2'b00,
        SCTC_H_WAIT = 2'b01
    } sctc_host_state_type;

endpackage

// file: logic/sctc_if.sv
// Carrier between the host controller and the sensor control logic.
// Assumes both ends run on the same clock; the bench joins them.
interface sctc_if;
    logic        cci_req;
    logic        cci_we;
    logic [15:0] cci_addr;
    logic [7:0]  cci_wdata;
    logic        cci_ack;
    logic [7:0]  cci_rdata;
    logic        hardware_clear_pin;
    logic        dev_standby;

    modport device (
        input  cci_req,
        input  cci_we,
        input  cci_addr,
        input  cci_wdata,
        input  hardware_clear_pin,
        output cci_ack,
        output cci_rdata,
        output dev_standby
    );

    modport host (
        output cci_req,
        output cci_we,
        output cci_addr,
        output cci_wdata,
        output hardware_clear_pin,
        input  cci_ack,
        input  cci_rdata,
        input  dev_standby
    );
endinterface

// file: logic/sctc_host.sv
// Host controller end: issues register accesses and drives the clear pin.
// Assumes the device answers every request with a one-cycle ack.
module sctc_host
    import sctc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    sctc_if.host             bus,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [15:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    input  wire logic        power_on,
    input  wire logic        power_off
);

    sctc_host_state_type state_q;
    logic        req_q, we_q, clr_q, off_q, rsp_q;
    logic [15:0] addr_q;
    logic [7:0]  wdata_q, rdat_q;

    wire take = cmd_valid && (state_q == SCTC_H_IDLE);

    // Request issue and answer capture; one access in flight.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= SCTC_H_IDLE;
            req_q   <= 1'b0;
            we_q    <= 1'b0;
            addr_q  <= 16'h0000;
            wdata_q <= 8'h00;
            rsp_q   <= 1'b0;
            rdat_q  <= 8'h00;
        end
        else
        begin
            req_q <= take;
            rsp_q <= 1'b0;
            if (take)
            begin
                state_q <= SCTC_H_WAIT;
                we_q    <= cmd_write;
                addr_q  <= cmd_addr;
                wdata_q <= cmd_wdata;
            end
            else if (state_q == SCTC_H_WAIT && bus.cci_ack)
            begin
                state_q <= SCTC_H_IDLE;
                rsp_q   <= 1'b1;
                rdat_q  <= bus.cci_rdata;
            end
        end
    end

    // Clear pin: held low at reset, dropped only once in standby.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clr_q <= 1'b0;
            off_q <= 1'b0;
        end
        else
        begin
            if (power_off && clr_q)
                off_q <= 1'b1;
            if (off_q && bus.dev_standby)
            begin
                clr_q <= 1'b0;
                off_q <= 1'b0;
            end
            else if (power_on && !off_q)
                clr_q <= 1'b1;
        end
    end

    assign bus.cci_req            = req_q;
    assign bus.cci_we             = we_q;
    assign bus.cci_addr           = addr_q;
    assign bus.cci_wdata          = wdata_q;
    assign bus.hardware_clear_pin = clr_q;
    assign cmd_ready              = (state_q == SCTC_H_IDLE);
    assign rsp_valid              = rsp_q;
    assign rsp_data               = rdat_q;

endmodule // sctc_host

// file: dv/sctc_properties.sv
// Checker on the carrier signals between the host and device ends.
// Assumes one clock; the bench places it beside the interface.
module sctc_properties
#(
    parameter int LINE_CYCLES  = 16,
    parameter int FRAME_CYCLES = 96
)
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cci_req,
    input wire logic        cci_we,
    input wire logic [15:0] cci_addr,
    input wire logic [7:0]  cci_wdata,
    input wire logic        cci_ack,
    input wire logic [7:0]  cci_rdata,
    input wire logic        hardware_clear_pin,
    input wire logic        dev_standby
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LINE_MAX  = LINE_CYCLES + 4;
    localparam int FRAME_MAX = FRAME_CYCLES + 4;
    logic run_wr;
    logic stop_req;
    logic fast_d;
    logic fast_q;

    // Run-state writes and a mirror of the fast-standby setting.
    assign run_wr   = cci_req && cci_we && cci_addr == 16'h0100;
    assign stop_req = run_wr && hardware_clear_pin && cci_wdata == 8'h00;
    assign fast_d   = (cci_req && cci_we && cci_addr == 16'h0106) ?
                      cci_wdata == 8'h01 : fast_q;

    // The clear pin wipes the device copy, so it wipes this one too.
    always_ff @(posedge clk)
    begin
        fast_q <= rst_n && hardware_clear_pin && fast_d;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_ack_follows_req: assert property (
        cci_req && hardware_clear_pin |=> cci_ack)
        else $error("Request got no ack.");
    a_ack_has_cause: assert property (
        cci_ack |-> $past(cci_req) && !$past(cci_ack))
        else $error("Ack without a request.");
    a_clear_in_standby: assert property (
        $fell(hardware_clear_pin) |-> $past(dev_standby))
        else $error("Clear pin fell outside standby.");
    a_clear_forces_reset: assert property (
        !hardware_clear_pin |=> dev_standby && !cci_ack)
        else $error("Clear pin did not reset the device.");
    a_stop_within_frame: assert property (
        stop_req |-> ##[1:FRAME_MAX] dev_standby)
        else $error("Standby not reached within a frame.");
    a_fast_stop_line: assert property (
        stop_req && fast_q |-> ##[1:LINE_MAX] dev_standby)
        else $error("Fast standby not reached within a line.");
    a_start_leaves_stby: assert property (
        run_wr && hardware_clear_pin && cci_wdata == 8'h01 && dev_standby
        |-> ##[1:3] !dev_standby)
        else $error("Start did not leave standby.");
    a_rdata_holds: assert property (
        hardware_clear_pin && $past(hardware_clear_pin) && !cci_ack
        |-> $stable(cci_rdata))
        else $error("Read data changed without an ack.");

    c_fast_stop: cover property (stop_req && fast_q);
    c_frame_stop: cover property (stop_req && !fast_q && !dev_standby);
    c_clear_fall: cover property ($fell(hardware_clear_pin));
endmodule // sctc_properties

// file: dv/test_standby_clock_temp_control.sv
// Bench joining the host and device ends through the carrier.
// Assumes short wake, line and measurement counts set at the instance.
module test_standby_clock_temp_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic        power_on, power_off, derate_on, crossing_ok, temp_busy;
    logic        streaming, frame_valid, line_valid, stby, pin;
    logic [15:0] cmd_addr, pix_rate, out_rate;
    logic [7:0]  cmd_wdata, rsp_data, pix_prediv, out_prediv, rd;
    logic signed [7:0] temp_celsius;
    int          n, err_count, checked;
    sctc_if bus();

    // Status taps on the carrier and the 50 MHz clock.
    assign stby = bus.dev_standby;
    assign pin  = bus.hardware_clear_pin;
    always #10 clk = ~clk;

    sctc_device #(.LINE_CYCLES(16), .ACT_LINES(4), .BLK_LINES(2),
                  .WAKE_CYCLES(20), .TEMP_CYCLES(8)) i_sctc_device (
        .clk(clk), .rst_n(rst_n), .bus(bus),
        .temp_celsius(temp_celsius), .pix_rate(pix_rate),
        .out_rate(out_rate), .derate_on(derate_on),
        .streaming(streaming), .frame_valid(frame_valid),
        .line_valid(line_valid), .crossing_ok(crossing_ok),
        .temp_busy(temp_busy), .pix_prediv(pix_prediv),
        .out_prediv(out_prediv));
    sctc_host i_sctc_host (
        .clk(clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .power_on(power_on), .power_off(power_off));
    // Checker defaults already match the short line and frame set above.
    sctc_properties i_sctc_properties (
        .clk(clk), .rst_n(rst_n), .cci_req(bus.cci_req),
        .cci_we(bus.cci_we), .cci_addr(bus.cci_addr),
        .cci_wdata(bus.cci_wdata), .cci_ack(bus.cci_ack),
        .cci_rdata(bus.cci_rdata), .dev_standby(bus.dev_standby),
        .hardware_clear_pin(bus.hardware_clear_pin));

    // Compares a value and reports a difference at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Checks that a condition held.
    task automatic ok(input logic c);
        check({7'h00, c}, 8'h01);
    endtask

    // Moves to just after the next rising edge.
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // Waits up to 400 cycles for a level; n holds the cycles spent.
    task automatic wait_lvl(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 400)
        begin
            step();
            n++;
        end
    endtask

    // One register access through the host; the answer lands in rd.
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'h1, w, a, d};
        step();
        cmd_valid = 1'h0;
        ok(cmd_ready === 1'h0);
        wait_lvl(rsp_valid, 1'h1);
        ok(rsp_valid === 1'h1);
        ok(cmd_ready === 1'h1);
        rd = rsp_data;
    endtask

    // Reads one register and compares it.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h00);
        check(rd, e);
    endtask

    // Starts streaming and waits for the first frame.
    task automatic start_frame();
        acc(1'h1, 16'h0100, 8'h01);
        wait_lvl(streaming, 1'h1);
        ok(streaming === 1'h1);
        wait_lvl(frame_valid, 1'h1);
    endtask

    // Reset values, an unmapped read and the pre-divider bands.
    task automatic t_regs();
        logic [7:0] fq [6] = '{8'h06, 8'h0B, 8'h0C, 8'h17, 8'h18, 8'h1B};
        logic [7:0] pd [6] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h03, 8'h03};
        rd_chk(16'h0100, 8'h00);
        rd_chk(16'h0106, 8'h00);
        rd_chk(16'h012B, 8'h0C);
        rd_chk(16'h0304, 8'h02);
        rd_chk(16'h0200, 8'h00);
        acc(1'h1, 16'h012A, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            acc(1'h1, 16'h012B, fq[i]);
            rd_chk(16'h0305, pd[i]);
            check(pix_prediv, pd[i]);
            check(out_prediv, pd[i]);
        end
    endtask

    // Crossing status for slower, faster and de-rated pixel rates.
    task automatic t_cross();
        {pix_rate, out_rate, derate_on} = {16'h0010, 16'h0020, 1'h0};
        step();
        ok(crossing_ok === 1'h1);
        out_rate = 16'h0008;
        step();
        ok(crossing_ok === 1'h0);
        derate_on = 1'h1;
        step();
        ok(crossing_ok === 1'h1);
    endtask

    // Measurement at stream start, re-runs, then a write to the result.
    task automatic t_temp();
        logic signed [7:0] tc [3] = '{8'h5F, 8'hF6, 8'h28};
        logic [7:0] te [3] = '{8'hFF, 8'h80, 8'hBD};
        acc(1'h1, 16'h0140, 8'h80);
        start_frame();
        ok(temp_busy === 1'h1);
        repeat (12) step();
        rd_chk(16'h0140, 8'hAB);
        for (int i = 0; i < 3; i++)
        begin
            temp_celsius = tc[i];
            acc(1'h1, 16'h0140, 8'h80);
            ok(temp_busy === 1'h1);
            repeat (12) step();
            rd_chk(16'h0140, te[i]);
        end
        acc(1'h1, 16'h0140, 8'h7F);
        rd_chk(16'h0140, 8'h3D);
    endtask

    // Stops in mid-frame, in blanking and in fast mode.
    task automatic t_stop();
        wait_lvl(frame_valid, 1'h0);
        wait_lvl(frame_valid, 1'h1);
        repeat (20) step();
        acc(1'h1, 16'h0100, 8'h00);
        ok(frame_valid === 1'h1 && stby === 1'h0);
        ok(line_valid === 1'h1);
        wait_lvl(stby, 1'h1);
        ok(n > 30 && n <= 64);
        start_frame();
        wait_lvl(frame_valid, 1'h0);
        acc(1'h1, 16'h0100, 8'h00);
        ok(stby === 1'h1);
        acc(1'h1, 16'h0106, 8'h01);
        start_frame();
        repeat (20) step();
        acc(1'h1, 16'h0100, 8'h00);
        wait_lvl(stby, 1'h1);
        ok(n <= 16);
    endtask

    // The clear pin waits for standby, then resets the fast-standby and temperature registers.
    task automatic t_power();
        start_frame();
        {power_on, power_off} = 2'h1;
        repeat (5) step();
        ok(pin === 1'h1);
        acc(1'h1, 16'h0100, 8'h00);
        wait_lvl(pin, 1'h0);
        ok(stby === 1'h1 && streaming === 1'h0);
        {power_on, power_off} = 2'h2;
        wait_lvl(pin, 1'h1);
        rd_chk(16'h0106, 8'h00);
        rd_chk(16'h0140, 8'h00);
    endtask

    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset for four cycles, power-up, then the scenarios in turn.
    initial
    begin
        {clk, rst_n, cmd_valid, cmd_write, power_on, power_off} = 6'h00;
        {cmd_addr, cmd_wdata, temp_celsius} = 32'h0000_0019;
        {pix_rate, out_rate, derate_on} = 33'h0;
        {err_count, checked} = 64'h0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'h1;
        power_on = 1'h1;
        repeat (3) step();
        t_regs();
        t_cross();
        t_temp();
        t_stop();
        t_power();
        finish_test();
    end

    // Cuts a hang short; the scenarios need well under 200 us.
    initial
    begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule // test_standby_clock_temp_control
